// ### acs_clock_select.sv
// Analyzer clock select: source choice, qualification, inhibit, delays,
// and the two memory clocks. Assumes external inputs are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module acs_clock_select (
    // System
    input wire logic clock,
    input wire logic rst_n,
    // Source selects, active low
    input wire logic fast_internal_select_n,
    input wire logic divided_internal_select_n,
    input wire logic rise_edge_select_n,
    input wire logic fall_edge_select_n,
    // Qualifier path enables, active low
    input wire logic qualifier_valid_low_path_enable_n,
    input wire logic qualifier_valid_high_path_enable_n,
    // Probe side
    input wire logic probeClock,
    input wire logic qualifier_in_true,
    input wire logic qualifier_in_inverted,
    input wire logic secondQualifierIn,
    input wire logic [7:0] firstProbeData,
    input wire logic [7:0] secondProbeData,
    // Internal sources and inhibits
    input wire logic dividedInternalClock,
    input wire logic inhibit_rise_path,
    input wire logic inhibit_fall_path,
    input wire logic inhibit_internal_paths,
    // Mode
    input wire logic probe_parallel_sense,
    // Outputs
    output logic fast_internal_clock,
    output logic qualifier_valid,
    output logic working_clock_out,
    output logic local_delayed_clock,
    output logic memory_delayed_clock,
    output logic first_memory_clock,
    output logic first_memory_delayed_clock,
    output logic second_memory_clock,
    output logic second_memory_delayed_clock,
    output logic [7:0] secondMemoryData
);
    localparam int LD = acs_pkg::LOCAL_DELAY_CYC;
    localparam int MD = acs_pkg::MEMORY_DELAY_CYC;
    localparam int FH = acs_pkg::FAST_HALF_CYC;

    // =========================================================
    // Input synchronisers: three stages, change when last two agree
    logic [2:0] clkSync_q, clkSync_d;
    logic [2:0] qtSync_q, qtSync_d;
    logic [2:0] qiSync_q, qiSync_d;
    logic [2:0] dvSync_q, dvSync_d;
    logic extClk_q, extClk_d, qTrue_q, qTrue_d, qInv_q, qInv_d;
    logic divClk_q, divClk_d;

    always_comb begin
        clkSync_d = {clkSync_q[1:0], probeClock};
        qtSync_d = {qtSync_q[1:0], qualifier_in_true};
        qiSync_d = {qiSync_q[1:0], qualifier_in_inverted};
        dvSync_d = {dvSync_q[1:0], dividedInternalClock};
        extClk_d = (clkSync_q[1] == clkSync_q[2]) ? clkSync_q[2] : extClk_q;
        qTrue_d = (qtSync_q[1] == qtSync_q[2]) ? qtSync_q[2] : qTrue_q;
        qInv_d = (qiSync_q[1] == qiSync_q[2]) ? qiSync_q[2] : qInv_q;
        divClk_d = (dvSync_q[1] == dvSync_q[2]) ? dvSync_q[2] : divClk_q;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clkSync_q <= 3'h0;
            qtSync_q <= 3'h0;
            qiSync_q <= 3'h0;
            dvSync_q <= 3'h0;
            extClk_q <= 1'b0;
            qTrue_q <= 1'b0;
            qInv_q <= 1'b0;
            divClk_q <= 1'b0;
        end else begin
            clkSync_q <= clkSync_d;
            qtSync_q <= qtSync_d;
            qiSync_q <= qiSync_d;
            dvSync_q <= dvSync_d;
            extClk_q <= extClk_d;
            qTrue_q <= qTrue_d;
            qInv_q <= qInv_d;
            divClk_q <= divClk_d;
        end
    end

    // =========================================================
    // Fast internal source: undivided 16 ns square wave
    logic [3:0] fastCnt_q, fastCnt_d;
    logic fastClk_q, fastClk_d;

    always_comb begin
        fastCnt_d = fastCnt_q + 4'h1;
        fastClk_d = fastClk_q;
        if (fastCnt_q == 4'(FH - 1)) begin
            fastCnt_d = 4'h0;
            fastClk_d = ~fastClk_q;
        end
    end

    // =========================================================
    // Qualifier and per-polarity latches
    logic qualNow;
    logic riseEn_q, riseEn_d, fallEn_q, fallEn_d;
    logic extInv;

    always_comb begin
        // Second probe qualifier deliberately unused
        qualNow = (!qualifier_valid_low_path_enable_n && !qTrue_q)
            || (!qualifier_valid_high_path_enable_n && !qInv_q)
            || (!qualifier_valid_low_path_enable_n && !qualifier_valid_high_path_enable_n);
        extInv = ~extClk_q;
        // Transparent while polarity low, held once it goes high
        riseEn_d = extClk_q ? riseEn_q : qualNow;
        fallEn_d = extInv ? fallEn_q : qualNow;
    end

    // =========================================================
    // Final selector and delay chains
    logic srcOne;
    logic workClk;
    logic [MD-1:0] delay_q, delay_d;
    logic [MD-1:0] bDelay_q, bDelay_d;
    logic bClk;

    always_comb begin
        // Exactly one source enable required, else no clock
        srcOne = ({3'h0, ~fast_internal_select_n}
            + {3'h0, ~divided_internal_select_n}
            + {3'h0, ~rise_edge_select_n}
            + {3'h0, ~fall_edge_select_n}) == 4'h1;
        workClk = srcOne && (
            (!fast_internal_select_n && !inhibit_internal_paths
                && fastClk_q)
            || (!divided_internal_select_n && !inhibit_internal_paths
                && divClk_q)
            || (!rise_edge_select_n && !inhibit_rise_path
                && riseEn_q && extClk_q)
            || (!fall_edge_select_n && !inhibit_fall_path
                && fallEn_q && extInv));
        // Second memory clock inverted in 2000-word mode
        bClk = probe_parallel_sense ? ~workClk : workClk;
        delay_d = {delay_q[MD-2:0], workClk};
        bDelay_d = {bDelay_q[MD-2:0], bClk};
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fastCnt_q <= 4'h0;
            fastClk_q <= acs_pkg::RESET_CLOCK;
            riseEn_q <= 1'b0;
            fallEn_q <= 1'b0;
            delay_q <= '0;
            bDelay_q <= '0;
            fast_internal_clock <= 1'b0;
            qualifier_valid <= 1'b0;
            working_clock_out <= 1'b0;
            local_delayed_clock <= 1'b0;
            memory_delayed_clock <= 1'b0;
            first_memory_clock <= 1'b0;
            first_memory_delayed_clock <= 1'b0;
            second_memory_clock <= 1'b0;
            second_memory_delayed_clock <= 1'b0;
            secondMemoryData <= 8'h00;
        end else begin
            fastCnt_q <= fastCnt_d;
            fastClk_q <= fastClk_d;
            riseEn_q <= riseEn_d;
            fallEn_q <= fallEn_d;
            delay_q <= delay_d;
            bDelay_q <= bDelay_d;
            fast_internal_clock <= fastClk_q;
            qualifier_valid <= qualNow;
            working_clock_out <= workClk;
            local_delayed_clock <= delay_q[LD-1];
            memory_delayed_clock <= delay_q[MD-1];
            first_memory_clock <= workClk;
            first_memory_delayed_clock <= delay_q[MD-1];
            second_memory_clock <= bClk;
            second_memory_delayed_clock <= bDelay_q[MD-1];
            // Probe paralleling for 2000-word mode
            secondMemoryData <= probe_parallel_sense
                ? firstProbeData : secondProbeData;
        end
    end

    // =========================================================
    // Checks
    a_inhibit_blocks_clock: assert property (@(posedge clock)
        disable iff (!rst_n)
        (inhibit_rise_path && inhibit_fall_path && inhibit_internal_paths)
        |=> !working_clock_out)
        else $error("working clock not blocked by inhibits");
    a_no_source_quiet: assert property (@(posedge clock)
        disable iff (!rst_n)
        (fast_internal_select_n && divided_internal_select_n
        && rise_edge_select_n && fall_edge_select_n) |=> !working_clock_out)
        else $error("clock produced with no source selected");
    a_memory_delay_match: assert property (@(posedge clock)
        disable iff (!rst_n)
        $rose(working_clock_out) |-> ##3 $rose(memory_delayed_clock))
        else $error("memory delayed clock misplaced");
    a_local_delay_match: assert property (@(posedge clock)
        disable iff (!rst_n)
        $rose(working_clock_out) |=> $rose(local_delayed_clock))
        else $error("local delayed clock misplaced");
    a_phase_inphase: assert property (@(posedge clock)
        disable iff (!rst_n)
        !$past(probe_parallel_sense)
        |-> second_memory_clock == first_memory_clock)
        else $error("memories not clocked in phase");
    a_phase_inverted: assert property (@(posedge clock)
        disable iff (!rst_n)
        $past(probe_parallel_sense)
        |-> second_memory_clock != first_memory_clock)
        else $error("second memory clock not inverted");
    a_qualifier_valid_any_true: assert property (@(posedge clock)
        disable iff (!rst_n)
        (!qualifier_valid_low_path_enable_n && !qualifier_valid_high_path_enable_n)
        |=> qualifier_valid)
        else $error("don't-care qualifier not true");
    a_qualifier_valid_none_false: assert property (@(posedge clock)
        disable iff (!rst_n)
        (qualifier_valid_low_path_enable_n && qualifier_valid_high_path_enable_n)
        |=> !qualifier_valid)
        else $error("qualifier true with no path enabled");
    a_parallel_data: assert property (@(posedge clock)
        disable iff (!rst_n)
        probe_parallel_sense |=> secondMemoryData == $past(firstProbeData))
        else $error("second memory not fed from first probe");
endmodule
`default_nettype wire

// ### acs_pkg.sv
// Constants for the analyzer clock select block.
// Assumes a 250 MHz system clock; all clocks here are sampled levels.
`default_nettype none
package acs_pkg;
    // =========================================================
    // Timing
    localparam int CLOCK_PERIOD_PS = 4000;
    localparam int LOCAL_DELAY_PS = 2500;
    localparam int MEMORY_DELAY_PS = 15000;
    localparam int FAST_PERIOD_PS = 20000;
    // Times round down; only the local delay is held to at least one cycle
    localparam int LOCAL_DELAY_CYC = (LOCAL_DELAY_PS / CLOCK_PERIOD_PS) < 1
        ? 1 : LOCAL_DELAY_PS / CLOCK_PERIOD_PS;
    localparam int MEMORY_DELAY_CYC = MEMORY_DELAY_PS / CLOCK_PERIOD_PS;
    localparam int FAST_HALF_CYC = FAST_PERIOD_PS / CLOCK_PERIOD_PS / 2;
    // =========================================================
    // Qualifier polarity selections
    typedef enum logic [1:0] {
        ACS_QUALIFIER_VALID_LOW = 2'h0,
        ACS_QUALIFIER_VALID_HIGH = 2'h1,
        ACS_QUALIFIER_VALID_ANY = 2'h2
    } acs_qualifier_valid_type;
    // =========================================================
    // Reset values
    localparam logic RESET_CLOCK = 1'b0;
endpackage
`default_nettype wire

// ### acs_probe_model.sv
// Probe stand-in: external sample clock and differential qualifier.
// Assumes the bench clock; the probe clock stands still when not running.
`timescale 1ns/1ps
`default_nettype none
module acs_probe_model (
    // System
    input wire logic clock,
    // Bench control
    input wire logic run,
    input wire logic qualLevel,
    // Probe pins
    output logic probeClock,
    output logic qualifier_in_true,
    output logic qualifier_in_inverted
);
    // ==========================================================
    // Probe clock, eight system cycles per period
    int phase;
    // Odd offset keeps edges away from the system clock edge
    always @(posedge clock) begin
        if (!run) begin
            phase <= 0;
            probeClock <= 1'b0;
        end else begin
            phase <= (phase + 1) % 4;
            if (phase == 3)
                probeClock <= #1.3 ~probeClock;
        end
    end
    // ==========================================================
    // Qualifier pair, always complementary
    always_comb begin
        qualifier_in_true = qualLevel;
        qualifier_in_inverted = ~qualLevel;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the analyzer clock select block.
// Assumes acs_probe_model drives the probe pins; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clock, rst_n, run, ql, inh, sense, q2, chk, pf;
    logic divClk = 1'b0;
    logic fic, qv, wc, lc, mc, fmc, fmdc, smc, smdc, pc, qt, qi;
    logic [3:0] selN;
    logic [1:0] qm;
    logic [7:0] d1, d2, smd;
    logic [2:0] hist = 3'h0;
    logic [31:0] seed;
    int errors, checked, divCnt, n, nf;
    // Fast, divided, two externals, idle and two illegal pairs
    logic [3:0] selTab [7] = '{4'hF, 4'h7, 4'hB, 4'hD, 4'hE, 4'h3, 4'h6};
    // ==========================================================
    // Clock and instances
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    acs_probe_model probe (.clock(clock), .run(run), .qualLevel(ql),
        .probeClock(pc), .qualifier_in_true(qt), .qualifier_in_inverted(qi));
    acs_clock_select uut (.clock(clock), .rst_n(rst_n),
        .fast_internal_select_n(selN[3]), .divided_internal_select_n(selN[2]),
        .rise_edge_select_n(selN[1]), .fall_edge_select_n(selN[0]),
        // Polarity 0, polarity 1, don't-care, then no path at all
        .qualifier_valid_low_path_enable_n(qm[0]),
        .qualifier_valid_high_path_enable_n(qm[0] ~^ qm[1]),
        .probeClock(pc), .qualifier_in_true(qt), .qualifier_in_inverted(qi),
        .secondQualifierIn(q2), .firstProbeData(d1), .secondProbeData(d2),
        .dividedInternalClock(divClk), .inhibit_rise_path(inh),
        .inhibit_fall_path(inh), .inhibit_internal_paths(inh),
        .probe_parallel_sense(sense), .fast_internal_clock(fic),
        .qualifier_valid(qv), .working_clock_out(wc),
        .local_delayed_clock(lc), .memory_delayed_clock(mc),
        .first_memory_clock(fmc), .first_memory_delayed_clock(fmdc),
        .second_memory_clock(smc), .second_memory_delayed_clock(smdc),
        .secondMemoryData(smd));
    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // Qualifier true for the chosen polarity and probe level
    function automatic logic expQual();
        return qm == 2'h2 || qm == {1'b0, ql};
    endfunction
    // Working clock rising edges in a 40-cycle window
    function automatic int expEdges();
        if (inh || $countones(~selN) != 1)
            return 0;
        if (!selN[3])
            return 10;
        if (!selN[2] || expQual())
            return 5;
        return 0;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string msg);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // ==========================================================
    // Divided source and per-cycle output relations
    always @(posedge clock) begin
        divCnt <= (divCnt + 1) % 4;
        if (divCnt == 3)
            divClk <= ~divClk;
        hist <= {hist[1:0], wc};
        if (chk) begin
            check(lc, hist[0], "local delay");
            check(mc, hist[2], "memory delay");
            check(fmc, wc, "first memory clock");
            check(smc, wc ^ sense, "second memory clock");
            check(fmdc, mc, "first delayed clock");
            check(smdc, mc ^ sense, "second delayed clock");
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        {rst_n, run, ql, inh, sense, q2, chk} = '0;
        selN = 4'hF;
        qm = 2'h0;
        d1 = 8'h00;
        d2 = 8'h00;
        seed = 32'h52;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        for (int i = 0; i < 28; i++) begin
            seed = xs(seed);
            selN <= selTab[i % 7];
            qm <= 2'(i / 7);
            ql <= seed[0];
            inh <= (i % 4 == 3);
            sense <= seed[1];
            q2 <= seed[2];
            d1 <= seed[15:8];
            d2 <= seed[23:16];
            run <= 1'b1;
            repeat (16) @(posedge clock);
            chk <= 1'b1;
            n = 0;
            nf = 0;
            pf = fic;
            for (int c = 0; c < 40; c++) begin
                @(posedge clock);
                if (wc && !hist[0])
                    n++;
                if (fic && !pf)
                    nf++;
                pf = fic;
            end
            chk <= 1'b0;
            check(n, expEdges(), "edges");
            check(nf, 40 / (2 * acs_pkg::FAST_HALF_CYC), "fast");
            check(qv, expQual(), "qualifier");
            check(smd, sense ? d1 : d2, "memory data");
        end
        finish_test();
    end
    // Whole run needs about 6.3 us
    initial begin
        #20000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
